// ==== rtl/pwr_mode_pkg.sv ====
// Contract
// - After reset, manual mode: the sleep request pin controls standby and run.
// - Manual mode wakes on pin release, powering analog then converter in fixed order.
// - Each manual wake runs exactly one frame; host may re-assert pin at once.
// - Automatic mode has run, first idle, second idle and sleep states.
// - Run frame rate: 1K below 4 ips, 2K from 4 to 8, 4K above 8.
// - Stay in run while motion keeps being detected.
// - After 50 ms without motion in run, enter first idle.
// - First idle wakes every 10 ms for one frame; motion returns to run.
// - After 8 s of first idle enter second idle, waking every 100 ms.
// - After 10 minutes of second idle enter sleep.
// - Sleep checks one frame like idle, but wakes only every 500 ms.
// - Low-power states do one frame, reload the wake timer, then sleep again.
// - Motion flag pin goes high when motion is detected.
// - After motion, run is not left until the host has read all motion data.
// - Config bit 0 of index 0x05 selects automatic mode; clear means pin control.
package pwr_mode_pkg;

  // ************************************************************
  // Clock, times and derived counts.
  // ************************************************************
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned RUN_IDLE_MS     = 50;
  localparam int unsigned FIRST_IDLE_STATE_WAKE_MS   = 10;
  localparam int unsigned FIRST_IDLE_STATE_DWELL_S   = 8;
  localparam int unsigned SECOND_IDLE_STATE_WAKE_MS   = 100;
  localparam int unsigned SLEEP_AFTER_MIN = 10;
  localparam int unsigned SLEEP_WAKE_MS   = 500;
  localparam int unsigned RC_HZ           = 1000;
  localparam int unsigned RC_DIV          = CLK_HZ / RC_HZ;
  localparam int unsigned RUN_IDLE_TICKS  = RUN_IDLE_MS * RC_HZ / 1000;
  localparam int unsigned FIRST_IDLE_STATE_TICKS     = FIRST_IDLE_STATE_WAKE_MS * RC_HZ / 1000;
  localparam int unsigned SECOND_IDLE_STATE_TICKS     = SECOND_IDLE_STATE_WAKE_MS * RC_HZ / 1000;
  localparam int unsigned SLEEP_TICKS     = SLEEP_WAKE_MS * RC_HZ / 1000;
  localparam int unsigned FIRST_IDLE_STATE_DWELL_TK  = FIRST_IDLE_STATE_DWELL_S * RC_HZ;
  localparam int unsigned SLEEP_AFTER_TK  = SLEEP_AFTER_MIN * 60 * RC_HZ;
  localparam int unsigned POWER_STEP_CYC  = 4;
  localparam int unsigned SPEED_LOW_IPS   = 4;
  localparam int unsigned SPEED_HIGH_IPS  = 8;

  // ************************************************************
  // Configuration register.
  // ************************************************************
  localparam logic [7:0] CFG_INDEX      = 8'h05;
  localparam int unsigned CFG_AUTO_BIT  = 0;
  localparam logic [7:0] CFG_RESET      = 8'h00;

  typedef enum logic [1:0] {RATE_1K, RATE_2K, RATE_4K} rate_t;
  typedef enum logic [1:0] {PS_RUN, PS_FIRST_IDLE_STATE, PS_SECOND_IDLE_STATE, PS_SLEEP} pstate_t;

  typedef struct packed {
    logic       analog_on;
    logic       dcdc_on;
    logic       frame_go;
    rate_t      rate;
    pstate_t    pstate;
  } pwr_out_t;

endpackage

// ==== rtl/pwr_mode_mgr.sv ====
`timescale 1ns/100ps
module pwr_mode_mgr
  import pwr_mode_pkg::*;
#(
  parameter int unsigned RC_DIV_P       = RC_DIV,
  parameter int unsigned FIRST_IDLE_STATE_DWELL_P  = FIRST_IDLE_STATE_DWELL_TK,
  parameter int unsigned SLEEP_AFTER_P  = SLEEP_AFTER_TK
) (
  input  wire logic       I_CLOCK,
  input  wire logic       I_RESET,
  input  wire logic       I_SLEEP_REQUEST,
  input  wire logic       I_CFG_WE,
  input  wire logic [7:0] I_CFG_INDEX,
  input  wire logic [7:0] I_CFG_DATA,
  input  wire logic       I_FRAME_DONE,
  input  wire logic       I_MOTION_SEEN,
  input  wire logic [5:0] I_SPEED_IPS,
  input  wire logic       I_DATA_PENDING,
  output logic            O_ANALOG_ON,
  output logic            O_DCDC_ON,
  output logic            O_FRAME_GO,
  output logic [1:0]      O_FRAME_RATE,
  output logic [1:0]      O_POWER_STATE,
  output logic            O_AUTO_MODE,
  output logic            O_MOTION_FLAG
);

  // ************************************************************
  // Sequencer states.
  // ************************************************************
  typedef enum logic [2:0] {SQ_OFF, SQ_ANALOG, SQ_DCDC, SQ_FRAME, SQ_WAIT} seq_t;

  seq_t        seq_q, seq_d;
  pstate_t     ps_q, ps_d;
  pwr_out_t    out_q, out_d;
  logic [7:0]  cfg_q;
  logic [31:0] div_q;
  logic [31:0] wake_q;
  logic [31:0] dwell_q;
  logic [2:0]  step_q;
  logic        flag_q;
  logic        run_q;
  logic        sleep_req_q;

  // ************************************************************
  // Decode.
  // ************************************************************
  wire auto_mode   = cfg_q[CFG_AUTO_BIT];
  wire cfg_hit     = I_CFG_WE && (I_CFG_INDEX == CFG_INDEX);
  wire rc_tick     = (div_q == RC_DIV_P - 1);
  wire step_done   = (step_q == 3'(POWER_STEP_CYC - 1));
  wire pin_falling = sleep_req_q && !I_SLEEP_REQUEST;
  wire wake_due    = rc_tick && (wake_q == 32'h0000_0001);
  wire frame_end   = (seq_q == SQ_FRAME) && I_FRAME_DONE;
  wire hold_run    = I_MOTION_SEEN || I_DATA_PENDING;
  wire [31:0] period = (ps_d == PS_FIRST_IDLE_STATE) ? 32'(FIRST_IDLE_STATE_TICKS) :
                       (ps_d == PS_SECOND_IDLE_STATE) ? 32'(SECOND_IDLE_STATE_TICKS) : 32'(SLEEP_TICKS);
  wire rate_t next_rate = (I_SPEED_IPS < 6'(SPEED_LOW_IPS))  ? RATE_1K :
                          (I_SPEED_IPS > 6'(SPEED_HIGH_IPS)) ? RATE_4K : RATE_2K;

  // ************************************************************
  // Power-up sequence and frame issue.
  // ************************************************************
  always_comb begin
    seq_d = seq_q;
    case (seq_q)
      SQ_OFF: begin
        // In run the sequencer must also start from off, or the first run after mode entry never frames.
        if ((!auto_mode && pin_falling) || (auto_mode && (run_q || wake_due))) begin
          seq_d = SQ_ANALOG;
        end
      end
      SQ_ANALOG: begin
        if (step_done) begin
          seq_d = SQ_DCDC;
        end
      end
      SQ_DCDC: begin
        if (step_done) begin
          seq_d = SQ_FRAME;
        end
      end
      SQ_FRAME: begin
        if (I_FRAME_DONE) begin
          seq_d = SQ_WAIT;
        end
      end
      SQ_WAIT: begin
        if (!auto_mode || !run_q) begin
          seq_d = SQ_OFF;
        end else begin
          seq_d = SQ_FRAME;
        end
      end
      default: seq_d = SQ_OFF;
    endcase
  end

  // ************************************************************
  // Automatic power state.
  // ************************************************************
  always_comb begin
    ps_d = ps_q;
    case (ps_q)
      PS_RUN: begin
        if (!hold_run && rc_tick && dwell_q >= 32'(RUN_IDLE_TICKS - 1)) begin
          ps_d = PS_FIRST_IDLE_STATE;
        end
      end
      PS_FIRST_IDLE_STATE: begin
        if (frame_end && I_MOTION_SEEN) begin
          ps_d = PS_RUN;
        end else if (rc_tick && dwell_q >= FIRST_IDLE_STATE_DWELL_P - 1) begin
          ps_d = PS_SECOND_IDLE_STATE;
        end
      end
      PS_SECOND_IDLE_STATE: begin
        if (frame_end && I_MOTION_SEEN) begin
          ps_d = PS_RUN;
        end else if (rc_tick && dwell_q >= SLEEP_AFTER_P - 1) begin
          ps_d = PS_SLEEP;
        end
      end
      PS_SLEEP: begin
        if (frame_end && I_MOTION_SEEN) begin
          ps_d = PS_RUN;
        end
      end
      default: ps_d = PS_RUN;
    endcase
    if (!auto_mode) begin
      ps_d = PS_RUN;
    end
  end

  always_comb begin
    out_d.analog_on = (seq_d != SQ_OFF);
    out_d.dcdc_on   = (seq_d == SQ_DCDC) || (seq_d == SQ_FRAME) || (seq_d == SQ_WAIT);
    out_d.frame_go  = (seq_q == SQ_DCDC && step_done) || (seq_q == SQ_WAIT && seq_d == SQ_FRAME);
    out_d.rate      = (ps_q == PS_RUN) ? next_rate : RATE_1K;
    out_d.pstate    = ps_d;
  end

  // ************************************************************
  // Registers.
  // ************************************************************
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      cfg_q <= CFG_RESET;
      seq_q <= SQ_OFF;
      ps_q  <= PS_RUN;
      out_q <= '0;
    end else begin
      if (cfg_hit) begin
        cfg_q <= I_CFG_DATA;
      end
      seq_q <= seq_d;
      ps_q  <= ps_d;
      out_q <= out_d;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      div_q       <= '0;
      step_q      <= '0;
      sleep_req_q <= 1'b1;
    end else begin
      div_q       <= rc_tick ? '0 : div_q + 32'h0000_0001;
      step_q      <= (seq_q == SQ_ANALOG || seq_q == SQ_DCDC) && !step_done ? step_q + 3'h1 : '0;
      sleep_req_q <= I_SLEEP_REQUEST;
    end
  end

  // The run flag keeps frames flowing continuously instead of through the RC timer.
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      run_q <= 1'b0;
    end else begin
      run_q <= auto_mode && (ps_d == PS_RUN);
    end
  end

  // Dwell counts RC ticks in the present state, except one landing on a second-idle frame end, and restarts on each state change.
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      dwell_q <= '0;
    end else if (ps_d != ps_q || (ps_q == PS_RUN && hold_run)) begin
      dwell_q <= '0;
    end else if (ps_q == PS_SECOND_IDLE_STATE && frame_end && !I_MOTION_SEEN) begin
      dwell_q <= dwell_q;
    end else if (rc_tick) begin
      dwell_q <= dwell_q + 32'h0000_0001;
    end
  end

  // Wake timer reloads on low-power state entry and after every low-power frame without motion, so each period starts at entry or frame end.
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      wake_q <= '0;
    end else if ((ps_d != PS_RUN && ps_d != ps_q) || (frame_end && ps_d != PS_RUN)) begin
      wake_q <= period;
    end else if (rc_tick && wake_q != 32'h0) begin
      wake_q <= wake_q - 32'h0000_0001;
    end
  end

  // Motion flag: a new detection wins over the host's read-out clearing it.
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      flag_q <= 1'b0;
    end else if (frame_end && I_MOTION_SEEN) begin
      flag_q <= 1'b1;
    end else if (!I_DATA_PENDING && !I_MOTION_SEEN) begin
      flag_q <= 1'b0;
    end
  end

  assign O_ANALOG_ON   = out_q.analog_on;
  assign O_DCDC_ON     = out_q.dcdc_on;
  assign O_FRAME_GO    = out_q.frame_go;
  assign O_FRAME_RATE  = out_q.rate;
  assign O_POWER_STATE = out_q.pstate;
  assign O_AUTO_MODE   = cfg_q[CFG_AUTO_BIT];
  assign O_MOTION_FLAG = flag_q;

endmodule

// ==== sim/pwr_mode_mgr_asserts.sv ====
`timescale 1ns/100ps
// ****************************************
// Checker for the power mode manager.
// ****************************************
module pwr_mode_mgr_chk (
  input wire logic       I_CLOCK,
  input wire logic       I_RESET,
  input wire logic       I_CFG_WE,
  input wire logic [7:0] I_CFG_INDEX,
  input wire logic [7:0] I_CFG_DATA,
  input wire logic       I_FRAME_DONE,
  input wire logic       I_MOTION_SEEN,
  input wire logic [5:0] I_SPEED_IPS,
  input wire logic       I_DATA_PENDING,
  input wire logic       O_ANALOG_ON,
  input wire logic       O_DCDC_ON,
  input wire logic       O_FRAME_GO,
  input wire logic [1:0] O_FRAME_RATE,
  input wire logic [1:0] O_POWER_STATE,
  input wire logic       O_AUTO_MODE,
  input wire logic       O_MOTION_FLAG
);
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (I_RESET);
  wire logic run_auto = O_AUTO_MODE && O_POWER_STATE == 2'h0;
  sequence s_analog_up; $rose(O_ANALOG_ON) && !O_AUTO_MODE; endsequence
  sequence s_dcdc_up; (!O_DCDC_ON)[*4] ##1 O_DCDC_ON; endsequence
  property p_reset; $fell(I_RESET) |-> !O_AUTO_MODE && O_POWER_STATE == 2'h0 && !O_ANALOG_ON; endproperty
  a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
  property p_cfg; I_CFG_WE && I_CFG_INDEX == 8'h05 |=> O_AUTO_MODE == $past(I_CFG_DATA[0]); endproperty
  a_cfg: assert property (p_cfg) else $error("mode bit not taken");
  property p_cfg_other; I_CFG_WE && I_CFG_INDEX != 8'h05 |=> $stable(O_AUTO_MODE); endproperty
  a_cfg_other: assert property (p_cfg_other) else $error("mode changed by other index");
  property p_wake; s_analog_up |-> s_dcdc_up ##4 O_FRAME_GO; endproperty
  a_wake: assert property (p_wake) else $error("wake order broken");
  property p_go_pulse; O_FRAME_GO |=> !O_FRAME_GO; endproperty
  a_go_pulse: assert property (p_go_pulse) else $error("frame start longer than a cycle");
  property p_one_frame; !O_AUTO_MODE && O_DCDC_ON && I_FRAME_DONE |-> ##[1:2] (!O_ANALOG_ON && !O_DCDC_ON); endproperty
  a_one_frame: assert property (p_one_frame) else $error("manual wake outlived its frame");
  property p_flag; O_AUTO_MODE && I_FRAME_DONE && I_MOTION_SEEN |=> O_MOTION_FLAG; endproperty
  a_flag: assert property (p_flag) else $error("motion flag not raised");
  property p_stay; run_auto && (I_MOTION_SEEN || I_DATA_PENDING) |=> O_POWER_STATE == 2'h0; endproperty
  a_stay: assert property (p_stay) else $error("run left with motion or pending data");
  property p_fast; (run_auto && I_SPEED_IPS > 6'd8)[*3] |-> O_FRAME_RATE == 2'h2; endproperty
  a_fast: assert property (p_fast) else $error("fast rate not chosen");
endmodule
bind pwr_mode_mgr pwr_mode_mgr_chk u_chk (.I_CLOCK, .I_RESET, .I_CFG_WE, .I_CFG_INDEX, .I_CFG_DATA, .I_FRAME_DONE,
  .I_MOTION_SEEN, .I_SPEED_IPS, .I_DATA_PENDING, .O_ANALOG_ON, .O_DCDC_ON, .O_FRAME_GO, .O_FRAME_RATE,
  .O_POWER_STATE, .O_AUTO_MODE, .O_MOTION_FLAG);

// ==== sim/host_model.sv ====
`timescale 1ns/100ps
// ****************************************
// Companion host and frame engine stand-in.
// ****************************************
module host_model #(
  parameter int LAT = 3
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic auto_mode,
  input  wire logic wake_req,
  input  wire logic frame_go,
  output logic      sleep_pin,
  output logic      frame_done
);
  int cnt = 0;
  initial begin
    sleep_pin = 1'b1;
    frame_done = 1'b0;
  end
  // The pin drops in manual mode while wake_req is high; a slow frame engine answers LAT cycles late.
  always @(negedge clk) begin
    sleep_pin <= rst | auto_mode | ~wake_req;
    frame_done <= (cnt == 1);
    if (rst) cnt <= 0;
    else if (frame_go) cnt <= LAT;
    else if (cnt != 0) cnt <= cnt - 1;
  end
endmodule

// ==== sim/tb_pwr_mode_mgr.sv ====
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin fail_count++; \
  $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module tb_pwr_mode_mgr;
  import pwr_mode_pkg::*;
  logic       clock, reset, wake, cfg_we, motion, pending, analog, dcdc, go, auto, flag, pin, done;
  logic [7:0] cfg_index, cfg_data;
  logic [5:0] speed;
  logic [1:0] rate, pstate;
  int         checks = 0, fail_count = 0, go_count = 0, n, m;
  logic [5:0] spd[6] = '{6'h00, 6'h03, 6'h04, 6'h08, 6'h09, 6'h28};
  logic [1:0] rt[6] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2};
  pwr_mode_mgr #(.RC_DIV_P(10), .FIRST_IDLE_STATE_DWELL_P(20), .SLEEP_AFTER_P(40)) uut (.I_CLOCK(clock), .I_RESET(reset),
    .I_SLEEP_REQUEST(pin), .I_CFG_WE(cfg_we), .I_CFG_INDEX(cfg_index), .I_CFG_DATA(cfg_data),
    .I_FRAME_DONE(done), .I_MOTION_SEEN(motion), .I_SPEED_IPS(speed), .I_DATA_PENDING(pending),
    .O_ANALOG_ON(analog), .O_DCDC_ON(dcdc), .O_FRAME_GO(go), .O_FRAME_RATE(rate), .O_POWER_STATE(pstate),
    .O_AUTO_MODE(auto), .O_MOTION_FLAG(flag));
  host_model #(.LAT(3)) host (.clk(clock), .rst(reset), .auto_mode(auto), .wake_req(wake), .frame_go(go),
    .sleep_pin(pin), .frame_done(done));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(negedge clock) go_count += go;
  task automatic tick(input int k);
    repeat (k) @(negedge clock);
  endtask
  task automatic wait_for(input bit on_go, input logic [1:0] s, input int lim, output int c);
    c = 0;
    do begin tick(1); c++; end while (c < lim && (on_go ? go !== 1'b1 : pstate !== s));
  endtask
  task automatic in_range(input string nm, input int c, input int lo, input int hi);
    `CHK(nm, 1'b1, (c >= lo && c <= hi))
  endtask
  task automatic cfg(input logic [7:0] idx, input logic [7:0] d);
    cfg_we <= 1'b1; cfg_index <= idx; cfg_data <= d;
    tick(1);
    cfg_we <= 1'b0;
    tick(1);
  endtask
  task automatic print_verdict;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    tick(30000);
    fail_count++;
    print_verdict();
  end
  initial begin
    reset = 1'b1; wake = 1'b0; cfg_we = 1'b0; cfg_index = 8'h00; cfg_data = 8'h00;
    motion = 1'b0; speed = 6'h00; pending = 1'b0;
    tick(4);
    reset <= 1'b0;
    tick(2);
    `CHK("auto", 1'b0, auto)
    go_count = 0;
    wake <= 1'b1;
    tick(1);
    wake <= 1'b0;
    wait_for(1, 2'h0, 20, n);
    `CHK("analog", 1'b1, analog)
    `CHK("dcdc", 1'b1, dcdc)
    tick(10);
    `CHK("frames", 1, go_count)
    `CHK("analog off", 1'b0, analog)
    cfg(8'h06, 8'h01);
    `CHK("auto other", 1'b0, auto)
    cfg(8'h05, 8'h01);
    `CHK("auto set", 1'b1, auto)
    motion <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      speed <= spd[i];
      tick(4);
      `CHK("rate", rt[i], rate)
    end
    tick(600);
    `CHK("run motion", 2'h0, pstate)
    motion <= 1'b0; pending <= 1'b1;
    tick(700);
    `CHK("run pending", 2'h0, pstate)
    `CHK("flag", 1'b1, flag)
    motion <= 1'b1; pending <= 1'b0;
    tick(2);
    motion <= 1'b0;
    wait_for(0, 2'h1, 700, n);
    in_range("to first_idle_state", n, 480, 520);
    wait_for(1, 2'h0, 150, n);
    in_range("first_idle_state wake", n, 90, 115);
    wait_for(0, 2'h2, 300, m);
    in_range("first_idle_state dwell", n + m, 190, 215);
    wait_for(0, 2'h3, 600, n);
    in_range("to sleep", n, 390, 415);
    motion <= 1'b1;
    wait_for(1, 2'h0, 5200, n);
    in_range("sleep wake", n, 4980, 5015);
    wait_for(0, 2'h0, 20, n);
    `CHK("back to run", 2'h0, pstate)
    `CHK("flag wake", 1'b1, flag)
    motion <= 1'b0;
    wait_for(0, 2'h1, 700, n);
    in_range("counters restart", n, 480, 520);
    reset <= 1'b1;
    tick(4);
    reset <= 1'b0;
    tick(1);
    `CHK("auto reset", 1'b0, auto)
    `CHK("state reset", 2'h0, pstate)
    print_verdict();
  end
endmodule
